// *** inc/hdvs_params.svh ***
// Offsets, field positions, reset values and codes of the video status stage
`ifndef HDVS_PARAMS_SVH
`define HDVS_PARAMS_SVH

`define HDVS_AW           8
`define HDVS_DW           32
`define HDVS_OFS_CTRL     8'h00
`define HDVS_OFS_STATUS   8'h04
`define HDVS_OFS_MASK     8'h08
`define HDVS_OFS_FLAGS    8'h0c
`define HDVS_OFS_LINE     8'h10
`define HDVS_CTRL_FW      0
`define HDVS_CTRL_RST     1'b0
`define HDVS_FLAG_W       5
`define HDVS_FLAG_RST     5'h00
`define HDVS_RD_RST       32'h0000_0000
`define HDVS_PIN_RST      2'b01

`define HDVS_TRS_ONES     10'h3ff
`define HDVS_TRS_ZERO     10'h000
`define HDVS_XYZ_ONE      9
`define HDVS_XYZ_F        8
`define HDVS_XYZ_V        7
`define HDVS_XYZ_H        6
`define HDVS_XYZ_P3       5
`define HDVS_XYZ_P2       4
`define HDVS_XYZ_P1       3
`define HDVS_XYZ_P0       2

`define HDVS_LN_W         11
`define HDVS_LN_RST       11'h000
`define HDVS_LN_STEP      11'h001
`define HDVS_LN_FIRST     11'h001
`define HDVS_LN_HI_TOP    4'h8
`define HDVS_WORD_RST     20'h00000
`define HDVS_HIST_RST     30'h00000000

`define HDVS_CRC_W        18
`define HDVS_CRC_TAPS     18'h03000
`define HDVS_CRC_RST      18'h00000
`endif

// *** inc/hdvs_pkg.sv ***
// Types shared by the video status stage
package hdvs_pkg;
`include "hdvs_params.svh"

   typedef struct packed {
      logic [9:0] luma;
      logic [9:0] chroma;
   } hdvs_word_t;

   typedef struct packed {
      logic chroma_crc_fault;
      logic luma_crc_fault;
      logic line_number_fault;
      logic start_marker_fault;
      logic end_marker_fault;
   } hdvs_flags_t;

   typedef struct packed {
      logic [2:0]            fvh;
      logic [`HDVS_LN_W-1:0] line;
   } hdvs_fw_t;

   typedef enum logic [2:0] {
      ST_BLANK,
      ST_ACTIVE,
      ST_LN0,
      ST_LN1,
      ST_CR0,
      ST_CR1
   } hdvs_state_t;
endpackage

// *** verilog/hdvs_pin_sync.sv ***
// Three-stage synchroniser for asynchronous control pins
`timescale 1ns/100ps
module hdvs_pin_sync #(
   parameter int           W   = 2,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Pins and clean levels
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic s1_q, s2_q, s3_q;
         logic lvl_d, lvl_q;
         // Change accepted only once stages two and three agree
         always_comb begin
            lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q  <= RST[g];
               s2_q  <= RST[g];
               s3_q  <= RST[g];
               lvl_q <= RST[g];
            end else if (ce) begin
               s1_q  <= pin[g];
               s2_q  <= s1_q;
               s3_q  <= s2_q;
               lvl_q <= lvl_d;
            end
         end
         assign level[g] = lvl_q;
      end
   endgenerate
endmodule

// *** verilog/hdvs_status_out.sv ***
// Output and status stage: TRS, line number and CRC checks, load strobe, APB
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "hdvs_params.svh"

// Notes on behaviour
// - Chroma CRC flag is high when the computed chroma line CRC differs from the embedded one.
// - Luma CRC flag is high when the computed luma line CRC differs from the embedded one.
// - The FIFO load strobe idles high and goes low for exactly the EAV or SAV word as selected.
// - Output drive low enables all twenty output bits; high leaves them undriven.
// - Luma sits on output bits 19 down to 10, MSB on bit 19.
// - Chroma sits on output bits 9 down to 0, MSB on bit 9.
// - Line fault rises on a malformed line number or, with flywheel on, a flywheel mismatch.
// - Line numbers are checked against the previous one, so one bad number faults two lines.
// - Start marker fault rises on a corrupt SAV or, with flywheel on, a predicted SAV mismatch.
// - End marker fault rises on a corrupt EAV or, with flywheel on, a predicted EAV mismatch.
// - The source supplies a 20-bit word, MSB bit 19, taken as delivered without alignment.
// - Inputs are sampled and outputs and flags updated on the rising pixel clock edge.
module hdvs_status_out #(
   parameter logic LOAD_SEL_EAV_LEVEL = 1'b1
) (
   // Clock, reset, enable
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      ce,
   // APB slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`HDVS_AW-1:0]       paddr,
   input  wire logic [`HDVS_DW-1:0]       pwdata,
   output logic      [`HDVS_DW-1:0]       prdata,
   output logic                           pready,
   output logic                           pslverr,
   // Upstream word and flywheel prediction
   input  wire hdvs_pkg::hdvs_word_t      data_in,
   input  wire hdvs_pkg::hdvs_fw_t        fw_pred,
   // Asynchronous control pins
   input  wire logic                      output_drive_n,
   input  wire logic                      load_point_sel,
   // Video and status outputs
   output hdvs_pkg::hdvs_word_t           video_out,
   output logic      [19:0]               video_oe,
   output logic                           fifo_load_n,
   output hdvs_pkg::hdvs_flags_t          flags,
   output logic                           irq
);
   import hdvs_pkg::*;

   function automatic logic xyz_bad(input logic [9:0] w);
      logic f, v, h;
      f = w[`HDVS_XYZ_F];
      v = w[`HDVS_XYZ_V];
      h = w[`HDVS_XYZ_H];
      xyz_bad = !w[`HDVS_XYZ_ONE] || (w[`HDVS_XYZ_P3] != (v ^ h)) ||
                (w[`HDVS_XYZ_P2] != (f ^ h)) || (w[`HDVS_XYZ_P1] != (f ^ v)) ||
                (w[`HDVS_XYZ_P0] != (f ^ v ^ h));
   endfunction

   // Bit-serial form of the line CRC, LSB of the word first
   function automatic logic [`HDVS_CRC_W-1:0] crc_step(input logic [`HDVS_CRC_W-1:0] c,
                                                       input logic [9:0] w);
      logic [`HDVS_CRC_W-1:0] r;
      logic                   fb;
      r = c;
      for (int i = 0; i < 10; i++) begin
         fb = r[0] ^ w[i];
         r  = {fb, r[`HDVS_CRC_W-1:1]} ^ (fb ? `HDVS_CRC_TAPS : `HDVS_CRC_RST);
      end
      crc_step = r;
   endfunction

   function automatic logic reg_known(input logic [`HDVS_AW-1:0] a);
      reg_known = (a == `HDVS_OFS_CTRL) || (a == `HDVS_OFS_STATUS) ||
                  (a == `HDVS_OFS_MASK) || (a == `HDVS_OFS_FLAGS) ||
                  (a == `HDVS_OFS_LINE);
   endfunction

   // Control pins
   logic [1:0] pin_lvl;
   logic       drive_n_s;
   logic       sel_eav_s;
   hdvs_pin_sync #(
      .W   (2),
      .RST (`HDVS_PIN_RST)
   ) u_pin_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .ce    (ce),
      .pin   ({load_point_sel, output_drive_n}),
      .level (pin_lvl)
   );
   assign drive_n_s = pin_lvl[0];
   assign sel_eav_s = (pin_lvl[1] == LOAD_SEL_EAV_LEVEL);
   // Video path state
   hdvs_word_t                   video_d, video_q;
   logic [2:0][9:0]              hist_d, hist_q;
   logic                         load_n_d, load_n_q;
   hdvs_state_t                  state_d, state_q;
   logic [1:0][`HDVS_CRC_W-1:0]  crc_d, crc_q;
   logic [1:0][8:0]              cr0_d, cr0_q;
   logic [6:0]                   ln_lo_d, ln_lo_q;
   logic                         ln_fmt_d, ln_fmt_q;
   logic [`HDVS_LN_W-1:0]        ln_prev_d, ln_prev_q;
   hdvs_flags_t                  flags_d, flags_q;
   hdvs_flags_t                  ev;
   logic [1:0][9:0]              ch;
   logic                         fw_en;
   logic                         trs, is_eav, is_sav, trs_bad;
   logic                         ln_done, ln_bad, ln_seq_bad;
   logic [`HDVS_LN_W-1:0]        ln_cur;
   logic                         crc_done;
   logic [1:0]                   mism;

   always_comb begin
      ch         = data_in;
      video_d    = data_in;
      hist_d     = {hist_q[1:0], data_in.luma};
      trs        = (hist_q[2] == `HDVS_TRS_ONES) && (hist_q[1] == `HDVS_TRS_ZERO) &&
                   (hist_q[0] == `HDVS_TRS_ZERO);
      is_eav     = trs && data_in.luma[`HDVS_XYZ_H];
      is_sav     = trs && !data_in.luma[`HDVS_XYZ_H];
      // Flywheel compare only on F, V, H; protection bits are covered by xyz_bad
      trs_bad    = xyz_bad(data_in.luma) ||
                   (fw_en && (data_in.luma[`HDVS_XYZ_F:`HDVS_XYZ_H] != fw_pred.fvh));
      load_n_d   = !((is_eav && sel_eav_s) || (is_sav && !sel_eav_s));
      state_d    = state_q;
      crc_d      = crc_q;
      cr0_d      = cr0_q;
      ln_lo_d    = ln_lo_q;
      ln_fmt_d   = ln_fmt_q;
      ln_prev_d  = ln_prev_q;
      ln_done    = 1'b0;
      crc_done   = 1'b0;
      mism       = 2'b00;
      ln_cur     = {ch[1][`HDVS_XYZ_P3:`HDVS_XYZ_P0], ln_lo_q};
      ln_seq_bad = (ln_cur != ln_prev_q + `HDVS_LN_STEP) && (ln_cur != `HDVS_LN_FIRST);
      ln_bad     = ln_fmt_q || (ch[1][9:6] != `HDVS_LN_HI_TOP) || ln_seq_bad ||
                   (fw_en && (ln_cur != fw_pred.line));
      unique case (state_q)
         ST_BLANK: begin
         end
         ST_ACTIVE: begin
            for (int i = 0; i < 2; i++) begin
               crc_d[i] = crc_step(crc_q[i], ch[i]);
            end
            if (is_eav) begin
               state_d = ST_LN0;
            end
         end
         ST_LN0: begin
            for (int i = 0; i < 2; i++) begin
               crc_d[i] = crc_step(crc_q[i], ch[i]);
            end
            ln_lo_d  = ch[1][`HDVS_XYZ_F:`HDVS_XYZ_P0];
            ln_fmt_d = (ch[1][`HDVS_XYZ_ONE] == ch[1][`HDVS_XYZ_F]);
            state_d  = ST_LN1;
         end
         ST_LN1: begin
            for (int i = 0; i < 2; i++) begin
               crc_d[i] = crc_step(crc_q[i], ch[i]);
            end
            ln_done   = 1'b1;
            ln_prev_d = ln_cur;
            state_d   = ST_CR0;
         end
         ST_CR0: begin
            for (int i = 0; i < 2; i++) begin
               cr0_d[i] = ch[i][8:0];
            end
            state_d = ST_CR1;
         end
         ST_CR1: begin
            crc_done = 1'b1;
            for (int i = 0; i < 2; i++) begin
               mism[i] = (crc_q[i] != {ch[i][8:0], cr0_q[i]});
            end
            state_d = ST_BLANK;
         end
         default: begin
            state_d = ST_BLANK;
         end
      endcase
      // SAV restarts the line from any state, so a lost EAV cannot wedge it
      if (is_sav) begin
         state_d = ST_ACTIVE;
         crc_d   = {2{`HDVS_CRC_RST}};
      end
      flags_d = flags_q;
      ev      = '0;
      if (crc_done) begin
         flags_d.luma_crc_fault   = mism[1];
         flags_d.chroma_crc_fault = mism[0];
         ev.luma_crc_fault        = mism[1];
         ev.chroma_crc_fault      = mism[0];
      end
      if (ln_done) begin
         flags_d.line_number_fault = ln_bad;
         ev.line_number_fault      = ln_bad;
      end
      if (is_sav) begin
         flags_d.start_marker_fault = trs_bad;
         ev.start_marker_fault      = trs_bad;
      end
      if (is_eav) begin
         flags_d.end_marker_fault = trs_bad;
         ev.end_marker_fault      = trs_bad;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         video_q   <= `HDVS_WORD_RST;
         hist_q    <= `HDVS_HIST_RST;
         load_n_q  <= 1'b1;
         state_q   <= ST_BLANK;
         crc_q     <= {2{`HDVS_CRC_RST}};
         cr0_q     <= '0;
         ln_lo_q   <= '0;
         ln_fmt_q  <= 1'b0;
         ln_prev_q <= `HDVS_LN_RST;
         flags_q   <= `HDVS_FLAG_RST;
      end else if (ce) begin
         video_q   <= video_d;
         hist_q    <= hist_d;
         load_n_q  <= load_n_d;
         state_q   <= state_d;
         crc_q     <= crc_d;
         cr0_q     <= cr0_d;
         ln_lo_q   <= ln_lo_d;
         ln_fmt_q  <= ln_fmt_d;
         ln_prev_q <= ln_prev_d;
         flags_q   <= flags_d;
      end
   end

   assign video_out   = video_q;
   assign video_oe    = {20{~drive_n_s}};
   assign fifo_load_n = load_n_q;
   assign flags       = flags_q;
   // Register file
   logic                     ctrl_d, ctrl_q;
   logic [`HDVS_FLAG_W-1:0]  status_d, status_q;
   logic [`HDVS_FLAG_W-1:0]  mask_d, mask_q;
   logic [`HDVS_DW-1:0]      prdata_d, prdata_q;
   logic                     wr;
   always_comb begin
      wr       = psel && penable && pwrite;
      ctrl_d   = ctrl_q;
      mask_d   = mask_q;
      // Set wins over a clear in the same cycle
      status_d = status_q | ev;
      prdata_d = prdata_q;
      if (wr) begin
         case (paddr)
            `HDVS_OFS_CTRL:   ctrl_d   = pwdata[`HDVS_CTRL_FW];
            `HDVS_OFS_STATUS: status_d = (status_q & ~pwdata[`HDVS_FLAG_W-1:0]) | ev;
            `HDVS_OFS_MASK:   mask_d   = pwdata[`HDVS_FLAG_W-1:0];
            default:          ;
         endcase
      end
      // Read data captured in the setup cycle so the access phase needs no wait
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `HDVS_OFS_CTRL:   prdata_d = {{(`HDVS_DW-1){1'b0}}, ctrl_q};
            `HDVS_OFS_STATUS: prdata_d = {{(`HDVS_DW-`HDVS_FLAG_W){1'b0}}, status_q};
            `HDVS_OFS_MASK:   prdata_d = {{(`HDVS_DW-`HDVS_FLAG_W){1'b0}}, mask_q};
            `HDVS_OFS_FLAGS:  prdata_d = {{(`HDVS_DW-`HDVS_FLAG_W){1'b0}}, flags_q};
            `HDVS_OFS_LINE:   prdata_d = {{(`HDVS_DW-`HDVS_LN_W){1'b0}}, ln_prev_q};
            default:          prdata_d = `HDVS_RD_RST;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= `HDVS_CTRL_RST;
         status_q <= `HDVS_FLAG_RST;
         mask_q   <= `HDVS_FLAG_RST;
         prdata_q <= `HDVS_RD_RST;
      end else if (ce) begin
         ctrl_q   <= ctrl_d;
         status_q <= status_d;
         mask_q   <= mask_d;
         prdata_q <= prdata_d;
      end
   end
   assign fw_en   = ctrl_q;
   assign prdata  = prdata_q;
   // Stalls while frozen, so no write can slip past a halted block; a read whose setup cycle falls in a freeze returns stale data
   assign pready  = ce;
   assign pslverr = psel && penable && !reg_known(paddr);
   assign irq     = |(status_q & mask_q);

   // Checks, sampled only on enabled edges
   default clocking cb @(posedge pclk iff ce);
   endclocking
   default disable iff (!presetn);
   property p_load_once;
      !fifo_load_n |=> fifo_load_n;
   endproperty
   a_load_once: assert property (p_load_once) else $error("load strobe longer than one word");
   property p_load_word;
      !fifo_load_n |-> video_out.luma[`HDVS_XYZ_ONE] &&
         ($past(video_out.luma, 3) == `HDVS_TRS_ONES) &&
         ($past(video_out.luma, 2) == `HDVS_TRS_ZERO) &&
         (video_out.luma[`HDVS_XYZ_H] == sel_eav_s);
   endproperty
   a_load_word: assert property (p_load_word) else $error("load strobe not on selected marker");
   property p_drive_on;
      (!output_drive_n) [*4] |=> (video_oe == 20'hfffff);
   endproperty
   a_drive_on: assert property (p_drive_on) else $error("output not driven");
   property p_drive_off;
      output_drive_n [*4] |=> (video_oe == 20'h00000);
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("output still driven");
   property p_luma;
      1'b1 |=> (video_out[19:10] == $past(data_in.luma));
   endproperty
   a_luma: assert property (p_luma) else $error("luma not on upper bits");
   property p_chroma;
      1'b1 |=> (video_out[9:0] == $past(data_in.chroma));
   endproperty
   a_chroma: assert property (p_chroma) else $error("chroma not on lower bits");
   property p_crc_y;
      crc_done |=> (flags.luma_crc_fault == $past(mism[1]));
   endproperty
   a_crc_y: assert property (p_crc_y) else $error("luma CRC flag wrong");
   property p_crc_c;
      crc_done |=> (flags.chroma_crc_fault == $past(mism[0]));
   endproperty
   a_crc_c: assert property (p_crc_c) else $error("chroma CRC flag wrong");
   property p_crc_hold;
      !crc_done |=> $stable({flags.luma_crc_fault, flags.chroma_crc_fault});
   endproperty
   a_crc_hold: assert property (p_crc_hold) else $error("CRC flag moved between lines");
   property p_ln;
      ln_done |=> (flags.line_number_fault == $past(ln_bad)) && ($past(state_q) == ST_LN1);
   endproperty
   a_ln: assert property (p_ln) else $error("line number flag wrong");
   property p_ln_prev;
      ln_done |=> (ln_prev_q == $past(ln_cur)) ##1 (ln_prev_q == $past(ln_prev_q));
   endproperty
   a_ln_prev: assert property (p_ln_prev) else $error("previous line number lost");
   property p_sav;
      is_sav |=> (flags.start_marker_fault == $past(trs_bad)) && (state_q == ST_ACTIVE);
   endproperty
   a_sav: assert property (p_sav) else $error("start marker flag wrong");
   property p_eav;
      is_eav && (state_q == ST_ACTIVE) |=> (flags.end_marker_fault == $past(trs_bad))
         ##1 (state_q == ST_LN1);
   endproperty
   a_eav: assert property (p_eav) else $error("end marker flag wrong");
   property p_line_seq;
      is_eav && (state_q == ST_ACTIVE) ##3 1'b1;
   endproperty
   c_line_seq: cover property (p_line_seq);
   property p_crc_fault_seen;
      crc_done && (mism != 2'b00);
   endproperty
   c_crc_fault_seen: cover property (p_crc_fault_seen);
   property p_irq_seen;
      $rose(irq);
   endproperty
   c_irq_seen: cover property (p_irq_seen);
endmodule

// *** bench/hdvs_fifo_model.sv ***
// Model of the external FIFO and video consumer on the output bus
`timescale 1ns/100ps
module hdvs_fifo_model (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Output bus of the stage
   input  wire hdvs_pkg::hdvs_word_t video_out,
   input  wire logic [19:0]          video_oe,
   input  wire logic                 fifo_load_n
);
   import hdvs_pkg::*;
   logic [19:0] bus;
   logic [19:0] held_q;
   logic [19:0] last_load;
   int          loads;
   // Released bits show the inverse of their last level, never a stale copy
   always_comb begin
      for (int i = 0; i < 20; i++) begin
         bus[i] = video_oe[i] ? video_out[i] : ~held_q[i];
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_q <= '0;
         loads  <= 0;
      end else begin
         held_q <= bus;
         if (fifo_load_n == 1'b0) begin
            loads     <= loads + 1;
            last_load <= bus;
         end
      end
   end
endmodule

// *** bench/hdvs_status_out_tb.sv ***
// Self-checking bench for the video output and status stage
`timescale 1ns/100ps
`include "hdvs_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module hdvs_status_out_tb;
   import hdvs_pkg::*;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
   logic        output_drive_n, load_point_sel, fifo_load_n, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] video_oe;
   logic [17:0] cy, cc;
   hdvs_word_t  data_in, video_out;
   hdvs_fw_t    fw_pred;
   hdvs_flags_t flags;
   int          n_fail, samples_checked;

   hdvs_status_out i_dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .data_in(data_in), .fw_pred(fw_pred),
      .output_drive_n(output_drive_n), .load_point_sel(load_point_sel),
      .video_out(video_out), .video_oe(video_oe), .fifo_load_n(fifo_load_n),
      .flags(flags), .irq(irq));
   hdvs_fifo_model i_fifo (
      .pclk(pclk), .presetn(presetn), .video_out(video_out),
      .video_oe(video_oe), .fifo_load_n(fifo_load_n));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [9:0] xyz(input logic f, input logic v, input logic h);
      return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
   endfunction

   // Serial line checksum, one bit at a time, low bit first
   function automatic logic [17:0] crc(input logic [17:0] c, input logic [9:0] d);
      logic fb;
      for (int i = 0; i < 10; i++) begin
         fb = c[0] ^ d[i];
         c  = {fb, c[17:1]} ^ (fb ? `HDVS_CRC_TAPS : 18'h00000);
      end
      return c;
   endfunction

   task print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task put(input logic [19:0] w);
      @(posedge pclk);
      data_in <= w;
   endtask

   task putc(input logic [9:0] y, input logic [9:0] c);
      put({y, c});
      cy = crc(cy, y);
      cc = crc(cc, c);
   endtask

   task idle(input int n);
      repeat (n) put({10'h040, 10'h200});
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         n_fail++;
         print_verdict;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // One line: SAV, active words, EAV, line number, checksums; fb spoils flywheel F
   task line(input logic [10:0] ln, input logic [10:0] fl, input logic fb,
             input logic [1:0] cb, input logic [1:0] tb, input logic [4:0] ef,
             input logic [4:0] cm);
      logic [9:0] s, e, a, b, h;
      int         n;
      s = xyz(1'b0, 1'b0, 1'b0) ^ {4'h0, tb[1], 5'h00};
      e = xyz(1'b0, 1'b0, 1'b1) ^ {4'h0, tb[0], 5'h00};
      a = {~ln[6], ln[6:0], 2'b00};
      b = {4'h8, ln[10:7], 2'b00};
      n = i_fifo.loads;
      fw_pred <= {fb, 2'b00, fl};
      for (int k = 0; k < 3; k++) begin
         put({2{(k == 0) ? 10'h3ff : 10'h000}});
      end
      put({s, s});
      cy = '0;
      cc = '0;
      for (int k = 0; k < 4; k++) begin
         putc(10'h040 + 10'(k), 10'h200 + 10'(k));
      end
      fw_pred <= {fb, 2'b01, fl};
      for (int k = 0; k < 3; k++) begin
         h = (k == 0) ? 10'h3ff : 10'h000;
         putc(h, h);
      end
      putc(e, e);
      putc(a, a);
      putc(b, b);
      put({~cy[8], cy[8:0] ^ {8'h00, cb[0]}, ~cc[8], cc[8:0] ^ {8'h00, cb[1]}});
      put({~cy[17], cy[17:9], ~cc[17], cc[17:9]});
      // Flags must still hold several words after the last update
      idle(4);
      `CHK("flags", ef & cm, flags & cm)
      `CHK("loads", n + 1, i_fifo.loads)
      `CHK("load word", {2{load_point_sel ? e : s}}, i_fifo.last_load)
   endtask

   initial begin
      n_fail = 0;
      samples_checked = 0;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      data_in = '0;
      fw_pred = '0;
      output_drive_n = 1'b1;
      load_point_sel = 1'b1;
      repeat (6) @(posedge pclk);
      `CHK("flags rst", 5'h00, flags)
      `CHK("load rst", 1'b1, fifo_load_n)
      `CHK("oe rst", 20'h00000, video_oe)
      `CHK("irq rst", 1'b0, irq)
      presetn <= 1'b1;
      $display("test reset done");
      apb(1'b0, `HDVS_OFS_CTRL, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped rd", 32'h0, rd)
      apb(1'b1, `HDVS_OFS_MASK, 32'h1f);
      apb(1'b0, `HDVS_OFS_MASK, 32'h0);
      `CHK("mask", 32'h1f, rd)
      $display("test registers done");
      output_drive_n <= 1'b0;
      idle(6);
      `CHK("oe on", 20'hfffff, video_oe)
      put({10'h2a5, 10'h15a});
      put({10'h040, 10'h200});
      #1;
      `CHK("luma", 10'h2a5, i_fifo.bus[19:10])
      `CHK("chroma", 10'h15a, i_fifo.bus[9:0])
      $display("test video done");
      line(1, 0, 0, 2'b00, 2'b00, 5'h00, 5'h1f);
      line(2, 0, 0, 2'b01, 2'b00, 5'h08, 5'h1f);
      line(3, 0, 0, 2'b10, 2'b00, 5'h10, 5'h1f);
      line(4, 0, 0, 2'b00, 2'b00, 5'h00, 5'h1f);
      line(7, 0, 0, 2'b00, 2'b00, 5'h04, 5'h1f);
      line(6, 0, 0, 2'b00, 2'b00, 5'h04, 5'h1f);
      line(7, 0, 0, 2'b00, 2'b00, 5'h00, 5'h1f);
      `CHK("irq on", 1'b1, irq)
      apb(1'b0, `HDVS_OFS_STATUS, 32'h0);
      `CHK("status", 32'h1c, rd)
      apb(1'b1, `HDVS_OFS_STATUS, 32'h1f);
      apb(1'b0, `HDVS_OFS_STATUS, 32'h0);
      `CHK("status clr", 32'h0, rd)
      `CHK("irq clr", 1'b0, irq)
      $display("test lines done");
      apb(1'b1, `HDVS_OFS_CTRL, 32'h1);
      load_point_sel <= 1'b0;
      idle(6);
      line(1, 1, 0, 2'b00, 2'b00, 5'h00, 5'h1f);
      line(2, 3, 0, 2'b00, 2'b00, 5'h04, 5'h1f);
      line(3, 3, 0, 2'b00, 2'b00, 5'h00, 5'h1f);
      line(4, 4, 1, 2'b00, 2'b00, 5'h03, 5'h1f);
      $display("test flywheel done");
      apb(1'b1, `HDVS_OFS_CTRL, 32'h0);
      line(1, 0, 0, 2'b00, 2'b01, 5'h01, 5'h01);
      line(1, 0, 0, 2'b00, 2'b10, 5'h02, 5'h02);
      line(1, 0, 0, 2'b00, 2'b00, 5'h00, 5'h1f);
      apb(1'b0, `HDVS_OFS_FLAGS, 32'h0);
      `CHK("flags reg", 32'h0, rd)
      apb(1'b0, `HDVS_OFS_LINE, 32'h0);
      `CHK("line reg", 32'h1, rd)
      apb(1'b1, `HDVS_OFS_MASK, 32'h0);
      #1;
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, `HDVS_OFS_MASK, 32'h1f);
      #1;
      `CHK("irq unmasked", 1'b1, irq)
      $display("test markers done");
      output_drive_n <= 1'b1;
      idle(6);
      `CHK("oe off", 20'h00000, video_oe)
      print_verdict;
   end

   initial begin
      #3000000;
      n_fail++;
      print_verdict;
   end
endmodule
